/* loader_pkg.sv */
// Shared constants and types for the serial flash configuration loader
package loader_pkg;

  // Clock rates
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 64;

  // Least wait between wake-up and fast read, rounded up to oscillator cycles
  localparam int WAKE_GAP_US = 30;
  localparam int WAKE_GAP_CYC = (WAKE_GAP_US * 1000 + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int GAP_W = 10;
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(WAKE_GAP_CYC - 1);

  // Flash instructions and frame layout
  localparam logic [7:0] CMD_WAKE = 8'hAB;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [23:0] START_ADDR = 24'h000000;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam int TX_W = 40;
  localparam int BIT_W = 6;
  localparam logic [BIT_W-1:0] WAKE_LAST = 6'h07;
  localparam logic [BIT_W-1:0] CMD_LAST = 6'h27;
  localparam logic [BIT_W-1:0] BYTE_LAST = 6'h07;

  // Serial clock phases: four oscillator cycles per bit, high for one cycle after phase 2
  localparam int PH_W = 2;
  localparam logic [PH_W-1:0] PH_FIRST = 2'h0;
  localparam logic [PH_W-1:0] PH_LAST = 2'h3;
  localparam int PH_SCK_BIT = 1;

  // Bitstream size and memory geometry
  localparam int CFG_BYTES = 256;
  localparam int CFG_AW = 8;
  localparam logic [CFG_AW-1:0] CFG_LAST = 8'hFF;

  // Configuration modes, strapped and caught at each restart
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_PASSIVE = 2'h1,
    MODE_JTAG = 2'h2
  } cfg_mode_e;

  // Load sequencer in the system domain
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_LOAD = 3'h2,
    S_DONE = 3'h4
  } load_state_e;

  // Flash link sequencer in the oscillator domain
  typedef enum logic [5:0] {
    L_IDLE = 6'h01,
    L_WAKE = 6'h02,
    L_GAP = 6'h04,
    L_CMD = 6'h08,
    L_DATA = 6'h10,
    L_END = 6'h20
  } link_state_e;

endpackage : loader_pkg

/* sync2.sv */
// Two flip-flop level synchroniser
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  ////////////////////////////////////////////////////////////////
  // First stage feeds only the second; no reset so that a level crossing
  // from another domain never meets a reset term
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout <= meta_q;
  end

endmodule : sync2

/* config_mem.sv */
// Volatile configuration memory, one write port and one registered read port
module config_mem
  import loader_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [CFG_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [CFG_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem_q [CFG_BYTES];

  ////////////////////////////////////////////////////////////////
  // Array holds no reset; content is meaningless until a load completes
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read data from a register, cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : config_mem

/* spi_flash_config_loader.sv */
// Configuration loader: restart detect, flash link on the oscillator clock, memory fill
module spi_flash_config_loader (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic osc_clk,
  input wire logic config_restart_n,
  input wire loader_pkg::cfg_mode_e cfg_mode,
  input wire logic ext_valid,
  input wire logic [7:0] ext_data,
  output logic ext_ready,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic user_mode,
  output logic load_busy,
  input wire logic [loader_pkg::CFG_AW-1:0] volatile_config_memory_rd_addr,
  output logic [7:0] volatile_config_memory_rd_data
);
  import loader_pkg::*;

  ////////////////////////////////////////////////////////////////
  // System domain declarations
  logic restart_s;
  logic restart_q;
  logic start;
  logic [1:0] mode_s;
  cfg_mode_e mode_q;
  load_state_e state_q;
  logic [CFG_AW-1:0] wr_cnt_q;
  logic user_mode_q;
  logic start_tog_q;
  logic req_s;
  logic req_q;
  logic new_byte;
  logic ack_tog_q;
  logic wr_en;
  logic [7:0] wr_data;

  // Oscillator domain declarations
  logic lrst_b;
  logic start_s;
  logic start_q;
  logic link_go;
  logic ack_s;
  logic miso_s;
  link_state_e lst_q;
  logic [PH_W-1:0] ph_q;
  logic [BIT_W-1:0] bit_q;
  logic [GAP_W-1:0] gap_q;
  logic [CFG_AW-1:0] byte_cnt_q;
  logic [TX_W-1:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] byte_q;
  logic req_tog_q;
  logic cs_n_q;
  logic sck_q;
  logic framing;
  logic hold;
  logic bit_end;

  ////////////////////////////////////////////////////////////////
  // Pin and byte request synchronisers into the system domain
  sync2 #(.W(1)) u_restart_sync (.clk(clk), .din(config_restart_n), .dout(restart_s));
  sync2 #(.W(2)) u_mode_sync (.clk(clk), .din(cfg_mode), .dout(mode_s));
  sync2 #(.W(1)) u_req_sync (.clk(clk), .din(req_tog_q), .dout(req_s));

  // Restart edge detect; edge register starts high so a pin already high does not start
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      restart_q <= 1'b1;
      req_q <= 1'b0;
    end else begin
      restart_q <= restart_s;
      req_q <= req_s;
    end
  end

  assign start = restart_s & ~restart_q;
  assign new_byte = req_s ^ req_q;

  // Mode strap caught at each restart edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= MODE_ACTIVE;
    end else if (start) begin
      mode_q <= cfg_mode_e'(mode_s);
    end
  end

  // Byte source: flash link in active mode, external port otherwise
  assign ext_ready = (state_q == S_LOAD) && (mode_q != MODE_ACTIVE);
  assign wr_data = (mode_q == MODE_ACTIVE) ? byte_q : ext_data;
  assign wr_en = (state_q == S_LOAD) && ((mode_q == MODE_ACTIVE) ? new_byte : ext_valid);

  // Load sequencer; a new restart always begins again from the first byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      wr_cnt_q <= '0;
    end else if (start) begin
      state_q <= S_LOAD;
      wr_cnt_q <= '0;
    end else if (wr_en) begin
      wr_cnt_q <= wr_cnt_q + 1'b1;
      if (wr_cnt_q == CFG_LAST) begin
        state_q <= S_DONE;
      end
    end
  end

  // Normal operation only once every byte is in memory
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      user_mode_q <= 1'b0;
    end else begin
      user_mode_q <= (state_q == S_DONE) && !start;
    end
  end

  assign user_mode = user_mode_q;
  assign load_busy = (state_q == S_LOAD);

  // Event crossings: start as a toggle out, byte acknowledge as a toggle back.
  // Acknowledge follows every byte even when not loading, so the link never hangs.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_tog_q <= 1'b0;
      ack_tog_q <= 1'b0;
    end else begin
      if (start && (cfg_mode_e'(mode_s) == MODE_ACTIVE)) begin
        start_tog_q <= ~start_tog_q;
      end
      if (new_byte) begin
        ack_tog_q <= ~ack_tog_q;
      end
    end
  end

  config_mem u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .wr_addr(wr_cnt_q),
    .wr_data(wr_data),
    .rd_addr(volatile_config_memory_rd_addr),
    .rd_data(volatile_config_memory_rd_data)
  );

  ////////////////////////////////////////////////////////////////
  // Oscillator domain: reset, start, acknowledge and data pin synchronisers
  sync2 #(.W(1)) u_lrst_sync (.clk(osc_clk), .din(rst_b), .dout(lrst_b));
  sync2 #(.W(1)) u_start_sync (.clk(osc_clk), .din(start_tog_q), .dout(start_s));
  sync2 #(.W(1)) u_ack_sync (.clk(osc_clk), .din(ack_tog_q), .dout(ack_s));
  sync2 #(.W(1)) u_miso_sync (.clk(osc_clk), .din(spi_miso), .dout(miso_s));

  always_ff @(posedge osc_clk) begin
    if (!lrst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_s;
    end
  end

  assign link_go = start_s ^ start_q;
  assign framing = (lst_q == L_WAKE) || (lst_q == L_CMD) || (lst_q == L_DATA);
  // Stall with the clock low until the system side has taken the last byte
  assign hold = (lst_q == L_DATA) && (req_tog_q != ack_s) && (ph_q == PH_FIRST);
  assign bit_end = framing && (ph_q == PH_LAST);

  // Bit phase counter; it only runs inside a frame, so the clock idles low
  always_ff @(posedge osc_clk) begin
    if (!lrst_b || link_go) begin
      ph_q <= PH_FIRST;
    end else if (framing && !hold) begin
      ph_q <= ph_q + 1'b1;
    end
  end

  // Registered serial clock and select
  always_ff @(posedge osc_clk) begin
    if (!lrst_b) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q <= framing && !hold && !link_go && ph_q[PH_SCK_BIT] && !(ph_q == PH_LAST);
      cs_n_q <= link_go ? framing : !(framing && !(bit_end && (lst_q != L_CMD) && last_bit()));
    end
  end

  // Last bit of the current frame segment
  function automatic logic last_bit();
    logic r;
    r = 1'b0;
    if (lst_q == L_WAKE) begin
      r = (bit_q == WAKE_LAST);
    end else if (lst_q == L_CMD) begin
      r = (bit_q == CMD_LAST);
    end else if (lst_q == L_DATA) begin
      r = (bit_q == BYTE_LAST) && (byte_cnt_q == CFG_LAST);
    end
    return r;
  endfunction : last_bit

  assign spi_sck = sck_q;
  assign spi_cs_n = cs_n_q;
  assign spi_mosi = tx_q[TX_W-1];

  // Link sequencer: wake, gap, fast read, data stream
  always_ff @(posedge osc_clk) begin
    if (!lrst_b) begin
      lst_q <= L_IDLE;
      bit_q <= '0;
      gap_q <= '0;
      byte_cnt_q <= '0;
      tx_q <= '0;
    end else if (link_go) begin
      lst_q <= L_WAKE;
      bit_q <= '0;
      byte_cnt_q <= '0;
      tx_q <= {CMD_WAKE, START_ADDR, DUMMY_BYTE};
    end else begin
      case (lst_q)
        L_WAKE: begin
          if (bit_end) begin
            tx_q <= {tx_q[TX_W-2:0], 1'b0};
            bit_q <= bit_q + 1'b1;
            if (bit_q == WAKE_LAST) begin
              lst_q <= L_GAP;
              gap_q <= '0;
            end
          end
        end
        L_GAP: begin
          gap_q <= gap_q + 1'b1;
          if (gap_q == GAP_LAST) begin
            lst_q <= L_CMD;
            bit_q <= '0;
            tx_q <= {CMD_FAST_READ, START_ADDR, DUMMY_BYTE};
          end
        end
        L_CMD: begin
          if (bit_end) begin
            tx_q <= {tx_q[TX_W-2:0], 1'b0};
            bit_q <= bit_q + 1'b1;
            if (bit_q == CMD_LAST) begin
              lst_q <= L_DATA;
              bit_q <= '0;
            end
          end
        end
        L_DATA: begin
          if (bit_end) begin
            bit_q <= bit_q + 1'b1;
            if (bit_q == BYTE_LAST) begin
              bit_q <= '0;
              byte_cnt_q <= byte_cnt_q + 1'b1;
              if (byte_cnt_q == CFG_LAST) begin
                lst_q <= L_END;
              end
            end
          end
        end
        L_END: begin
          lst_q <= L_IDLE;
        end
        default: begin
          lst_q <= L_IDLE;
        end
      endcase
    end
  end

  // Receive shifter and byte handover; the byte stands until acknowledged
  always_ff @(posedge osc_clk) begin
    if (!lrst_b) begin
      rx_q <= 8'h00;
      byte_q <= 8'h00;
      req_tog_q <= 1'b0;
    end else if ((lst_q == L_DATA) && bit_end) begin
      rx_q <= {rx_q[6:0], miso_s};
      if (bit_q == BYTE_LAST) begin
        byte_q <= {rx_q[6:0], miso_s};
        req_tog_q <= ~req_tog_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // System domain checks
  start_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    start |=> (state_q == S_LOAD) && (wr_cnt_q == '0))
    else $error("restart edge did not begin a load");

  user_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(user_mode_q) |-> $past(wr_cnt_q, 2) == CFG_LAST)
    else $error("normal operation before the last byte");

  no_user_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == S_LOAD) |=> !user_mode_q)
    else $error("normal operation while loading");

  jtag_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == S_LOAD) && (mode_q == MODE_JTAG) && ext_valid |=> wr_cnt_q == $past(wr_cnt_q) + 1'b1)
    else $error("jtag byte not written");

  // Oscillator domain checks
  wake_first_a: assert property (@(posedge osc_clk) disable iff (!lrst_b)
    link_go |=> (lst_q == L_WAKE) && (tx_q[TX_W-1 -: 8] == CMD_WAKE) ##1 !cs_n_q)
    else $error("first instruction is not wake-up");

  gap_wait_a: assert property (@(posedge osc_clk) disable iff (!lrst_b)
    $rose(lst_q == L_GAP) |-> (lst_q == L_GAP) [*8])
    else $error("wake gap cut short");

  gap_count_a: assert property (@(posedge osc_clk) disable iff (!lrst_b)
    $rose(lst_q == L_CMD) |-> $past(gap_q) == GAP_LAST)
    else $error("fast read before the wake gap ended");

  read_cmd_a: assert property (@(posedge osc_clk) disable iff (!lrst_b)
    $rose(lst_q == L_CMD) |-> tx_q == {CMD_FAST_READ, START_ADDR, DUMMY_BYTE})
    else $error("fast read frame wrong");

  select_hold_a: assert property (@(posedge osc_clk) disable iff (!lrst_b)
    (lst_q == L_DATA) && !$rose(lst_q == L_DATA) |-> !cs_n_q)
    else $error("select dropped during read");

  sck_idle_a: assert property (@(posedge osc_clk) disable iff (!lrst_b)
    cs_n_q |-> !sck_q)
    else $error("serial clock moving while deselected");

  start_cov: cover property (@(posedge clk) disable iff (!rst_b) start);
  done_cov: cover property (@(posedge clk) disable iff (!rst_b) $rose(user_mode_q));
  jtag_cov: cover property (@(posedge clk) disable iff (!rst_b) wr_en && (mode_q == MODE_JTAG));
  stall_cov: cover property (@(posedge osc_clk) disable iff (!lrst_b) hold [*4]);

endmodule : spi_flash_config_loader

/* spi_flash_model.sv */
// Behavioural serial flash that holds the bitstream and records what the loader sent it
module spi_flash_model (
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output int n_frames,
  output logic [7:0] first_cmd,
  output logic [39:0] rd_cmd,
  output int gap_ns,
  output int sck_per,
  output int n_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import loader_pkg::*;

  // Content pattern, byte n holds n xor salt
  localparam logic [7:0] SALT = 8'hA5;

  logic [39:0] sh;
  logic [7:0] cur;
  int nbits;
  int nd;
  logic opened;
  realtime wake_end;
  realtime rd_start;
  realtime last_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // Start state
  initial begin
    spi_miso = 1'b0;
    n_frames = 0;
    first_cmd = 8'h00;
    rd_cmd = 40'h0;
    gap_ns = 0;
    sck_per = 0;
    n_data = 0;
    wake_end = 0.0;
    opened = 1'b0;
  end

  // Frame opens: clear the shifter and note when the frame began
  always @(negedge spi_cs_n) begin
    opened = 1'b1;
    nbits = 0;
    nd = 0;
    sh = 40'h0;
    last_rise = 0.0;
    rd_start = $realtime;
  end

  // Mode 0 sampling on the rising edge; count data bits once the header is in
  always @(posedge spi_sck) begin
    if (!spi_cs_n) begin
      if (last_rise > 0.0) sck_per = int'($realtime - last_rise);
      last_rise = $realtime;
      if (nbits < 40) begin
        sh = {sh[38:0], spi_mosi};
        nbits++;
      end else begin
        nd++;
      end
    end
  end

  // Data changes on the falling edge; outside the read phase the line wanders
  always @(negedge spi_sck) begin
    cur = 8'(nd / 8) ^ SALT;
    if (!spi_cs_n && nbits == 40 && sh[39:32] == CMD_FAST_READ) spi_miso = cur[7 - nd % 8];
    else spi_miso = ~spi_miso;
  end

  // Frame closes: an eight bit frame is a wake-up, a longer one a read.
  // Only a frame that was opened counts, so the select settling out of reset is ignored.
  always @(posedge spi_cs_n) begin
    if (opened) begin
      opened = 1'b0;
      n_frames++;
      if (nbits == 8 && n_frames == 1) first_cmd = sh[7:0];
      if (nbits == 8) wake_end = $realtime;
      else begin
        rd_cmd = sh;
        gap_ns = int'(rd_start - wake_end);
        n_data = nd;
      end
    end
    spi_miso = ~spi_miso;
  end
endmodule : spi_flash_model

/* test_spi_flash_config_loader.sv */
// Self-checking bench for the configuration loader with a flash model on the link
module test_spi_flash_config_loader;
  timeunit 1ns;
  timeprecision 1ps;
  import loader_pkg::*;

  logic clk, rst_b, osc_clk, config_restart_n, ext_valid, ext_ready;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, user_mode, load_busy;
  cfg_mode_e cfg_mode;
  logic [7:0] ext_data, volatile_config_memory_rd_data, first_cmd;
  logic [CFG_AW-1:0] volatile_config_memory_rd_addr;
  logic [39:0] rd_cmd;
  int n_frames, gap_ns, sck_per, n_data;
  int n_fail = 0;
  int n_compared = 0;

  spi_flash_config_loader i_dut (.clk(clk), .rst_b(rst_b), .osc_clk(osc_clk), .config_restart_n(config_restart_n),
    .cfg_mode(cfg_mode), .ext_valid(ext_valid), .ext_data(ext_data), .ext_ready(ext_ready), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .user_mode(user_mode),
    .load_busy(load_busy), .volatile_config_memory_rd_addr(volatile_config_memory_rd_addr), .volatile_config_memory_rd_data(volatile_config_memory_rd_data));

  spi_flash_model i_flash (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .n_frames(n_frames), .first_cmd(first_cmd), .rd_cmd(rd_cmd), .gap_ns(gap_ns), .sck_per(sck_per),
    .n_data(n_data));

  ////////////////////////////////////////////////////////////////////////////////
  // Clocks: oscillator offset by 7 ns, yet its rising edges still meet clk rising edges every 320 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    osc_clk = 1'b0;
    #7;
    forever #32 osc_clk = ~osc_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // Low pulse long enough for the two flop synchroniser to see it
  task automatic restart_pulse(input cfg_mode_e mode);
    @(posedge clk);
    cfg_mode <= mode;
    config_restart_n <= 1'b0;
    repeat (8) @(posedge clk);
    config_restart_n <= 1'b1;
  endtask : restart_pulse

  task automatic wait_busy();
    for (int i = 0; i < 10 && load_busy !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(load_busy, 1'b1);
  endtask : wait_busy

  task automatic wait_user(input int lim);
    for (int i = 0; i < lim && user_mode !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(user_mode, 1'b1);
    check(load_busy, 1'b0);
  endtask : wait_user

  // Read back every byte; address set at an edge, data ready one edge later
  task automatic check_mem(input logic [7:0] salt);
    for (int a = 0; a < CFG_BYTES; a++) begin
      @(posedge clk);
      volatile_config_memory_rd_addr <= CFG_AW'(a);
      @(posedge clk);
      #1;
      check(volatile_config_memory_rd_data, 8'(a) ^ salt);
    end
  endtask : check_mem

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    repeat (10) @(posedge clk);
    #1;
    check(load_busy, 1'b0);
    check(user_mode, 1'b0);
    check(spi_cs_n, 1'b1);
    check(spi_sck, 1'b0);
    check(ext_ready, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // Active load cut short once mid-read, then run to the end
  task automatic t_active();
    restart_pulse(MODE_ACTIVE);
    wait_busy();
    check(ext_ready, 1'b0);
    wait (n_frames == 1);
    @(negedge spi_cs_n);
    #5us;
    restart_pulse(MODE_ACTIVE);
    repeat (4) @(posedge clk);
    check(load_busy, 1'b1);
    check(user_mode, 1'b0);
    wait_user(75000);
    check(n_frames, 4);
    check(first_cmd, CMD_WAKE);
    check(gap_ns >= WAKE_GAP_US * 1000, 1'b1);
    check(rd_cmd, {CMD_FAST_READ, START_ADDR, DUMMY_BYTE});
    check(n_data, CFG_BYTES * 8);
    check(spi_cs_n, 1'b1);
    check(sck_per, 4 * OSC_PERIOD_NS);
    check_mem(8'hA5);
    $display("test active done");
  endtask : t_active

  // Bytes from an outside master, back to back, one per accepted edge
  task automatic t_ext(input cfg_mode_e mode, input logic [7:0] salt);
    restart_pulse(mode);
    wait_busy();
    @(posedge clk);
    for (int i = 0; i < CFG_BYTES; i++) begin
      if (i == CFG_BYTES - 1) check(user_mode, 1'b0);
      ext_valid <= 1'b1;
      ext_data <= 8'(i) ^ salt;
      do @(posedge clk); while (ext_ready !== 1'b1);
    end
    ext_valid <= 1'b0;
    wait_user(10);
    check(spi_cs_n, 1'b1);
    check_mem(salt);
    $display("test external mode %0d done", mode);
  endtask : t_ext

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset is stretched so the oscillator side sees it too
  initial begin
    rst_b = 1'b0;
    config_restart_n = 1'b1;
    cfg_mode = MODE_ACTIVE;
    ext_valid = 1'b0;
    ext_data = 8'h00;
    volatile_config_memory_rd_addr = 8'h00;
    repeat (30) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_active();
    t_ext(MODE_PASSIVE, 8'h3C);
    t_ext(MODE_JTAG, 8'hC3);
    stop_test();
  end

  // Watchdog sized well past one full active load
  initial begin
    #900us;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : test_spi_flash_config_loader
